// ==== include/dio_defs.svh ====
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define CLK_HZ          40000000
`define US_TIME_NS      1000
`define US_CYCLES       ((`US_TIME_NS * (`CLK_HZ / 1000000)) / 1000)
`define START_PULSE_NS  500
`define START_PULSE_CYC ((`START_PULSE_NS * (`CLK_HZ / 1000000)) / 1000)
`define SEC_TIME_MS     1000
`define SEC_CYCLES      (`SEC_TIME_MS * (`CLK_HZ / 1000))
`define SEC_HIGH_MS     470
`define SEC_HIGH_CYCLES (`SEC_HIGH_MS * (`CLK_HZ / 1000))

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define DIR_OFS  8'h00
`define OUT_OFS  8'h04
`define IN_OFS   8'h08
`define CFG_OFS  8'h0c
`define CMD_OFS  8'h10
`define PER_OFS  8'h14
`define STAT_OFS 8'h18
`define MASK_OFS 8'h1c
`define INFO_OFS 8'h20

// ****************************************
// Fields and reset values
// ****************************************
`define CFG_START_LSB  0
`define CFG_SEC_LSB    2
`define CFG_STREAM_BIT 4
`define CMD_START_BIT  0
`define CMD_SAMPLE_BIT 1
`define MODE_EXT       2'h0
`define MODE_INT       2'h1
`define MODE_INTOUT    2'h2
`define CFG_RST        5'h00
`define OUT_RST        32'h0000_0000
`define PER_RST        14'h03e8
`define PER_MIN_US     14'h000a
`define PER_MAX_US     14'h2710
`define MASK_RST       3'h0
`define TAG_SEC_BIT    13
`define TAG_START_BIT  12

`endif

// ==== include/dio_pkg.sv ====
package dio_pkg;

    // Packet word toward the crate controller
    typedef struct packed {
        logic        cmd;
        logic [23:0] body;
    } tagpkt_s;

    // Synchronisation events of one cycle
    typedef struct packed {
        logic sec;
        logic start;
    } tag_ev_s;

    // Tag sender states
    typedef enum logic [1:0] {
        TAG_IDLE = 2'b01,
        TAG_SEND = 2'b10
    } tag_state_e;

endpackage

// ==== src/sync_rise.sv ====
`include "dio_defs.svh"

// Two-stage synchroniser with rising-edge detect behind it
module sync_rise #(
    parameter int W = 1
)(
    input  wire logic         clk,   // System clock
    input  wire logic         rst_b, // Async reset, active low
    input  wire logic [W-1:0] d,     // Raw pin levels
    output logic      [W-1:0] q,     // Synchronised levels
    output logic      [W-1:0] rise   // One-cycle rising-edge pulse
);
    logic [W-1:0] s1Reg;
    logic [W-1:0] s2Reg;
    logic [W-1:0] s3Reg;

    // Only the second stage reads the first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1Reg <= '0;
            s2Reg <= '0;
            s3Reg <= '0;
        end else begin
            s1Reg <= d;
            s2Reg <= s1Reg;
            s3Reg <= s2Reg;
        end
    end

    assign q    = s2Reg;
    assign rise = s2Reg & ~s3Reg; // see [RULE13]

    a_rise_delay: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(d[0]) |-> ##2 rise[0]) // see [RULE13]
        else $error("rising edge not reported two cycles later");
endmodule

// ==== src/tag_sender.sv ====
`include "dio_defs.svh"

// Holds pending tag events and hands one packet at a time out
module tag_sender (
    input  wire logic     clk,      // System clock
    input  wire logic     rst_b,    // Async reset, active low
    input  dio_pkg::tag_ev_s ev,    // Event pulses
    input  wire logic     pktReady, // Controller takes the packet
    output logic          pktValid, // Packet on offer
    output dio_pkg::tagpkt_s pkt,   // Packet word
    output logic          busy      // Packet waiting or events pending
);
    import dio_pkg::*;

    tag_state_e stateReg;
    tag_state_e stateNext;
    tag_ev_s    pendReg;
    tag_ev_s    pendNext;
    tagpkt_s    pktReg;
    tagpkt_s    pktNext;
    wire logic  load;

    // A new event during an outstanding packet waits in pend
    assign load = (stateReg == TAG_IDLE) && (pendReg != '0);
    assign pendNext = (load ? '0 : pendReg) | ev; // see [RULE6]

    // Tag word: command bit, second and start flags, rest zero
    always_comb begin
        pktNext = pktReg;
        stateNext = stateReg;
        case (stateReg)
            TAG_IDLE: begin
                if (load) begin
                    pktNext = '0;
                    pktNext.cmd = 1'b1; // see [RULE12]
                    pktNext.body[`TAG_SEC_BIT] = pendReg.sec;
                    pktNext.body[`TAG_START_BIT] = pendReg.start;
                    stateNext = TAG_SEND;
                end
            end
            TAG_SEND: begin
                if (pktReady) begin
                    stateNext = TAG_IDLE;
                end
            end
            default: stateNext = TAG_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stateReg <= TAG_IDLE;
            pendReg  <= '0;
            pktReg   <= '0;
        end else begin
            stateReg <= stateNext;
            pendReg  <= pendNext;
            pktReg   <= pktNext;
        end
    end

    assign pktValid = (stateReg == TAG_SEND);
    assign pkt      = pktReg;
    assign busy     = (stateReg == TAG_SEND) || (pendReg != '0);

    a_tag_format: assert property (@(posedge clk) disable iff (!rst_b)
        pktValid |-> pkt.cmd && pkt.body[23:14] == '0 // see [RULE12]
            && pkt.body[11:0] == '0 && pkt.body[13:12] != 2'h0)
        else $error("tag packet badly formed");
    a_tag_hold: assert property (@(posedge clk) disable iff (!rst_b)
        pktValid && !pktReady |=> pktValid && $stable(pkt)) // see [RULE6]
        else $error("tag packet withdrawn before taken");
    a_tag_kept: assert property (@(posedge clk) disable iff (!rst_b)
        ev.start && pktValid |=> pendReg.start) // see [RULE6]
        else $error("start event lost while busy");
endmodule

// ==== src/dio_sync_top.sv ====
// Operation
// [RULE1] Thirty-two lines in four 8-bit ports serve as unclocked I/O; the code registers outputs and samples inputs on mclk.
// [RULE2] Software sets each port to input or output on its own.
// [RULE3] A port with the forced-output strap drives zero from reset.
// [RULE4] Undriven lines read high, or low in the pull-down build.
// [RULE5] Streamed sampling runs at a period from 10 ms down to 10 us.
// [RULE6] Every sync event sends one tag packet to the controller; events pending together share one packet.
// [RULE7] Start and second events are independent with own modes.
// [RULE8] Start comes from the start line or from a software command.
// [RULE9] Internal start may be driven out as a pulse on the line.
// [RULE10] Second events are external, internal 1 s, or internal out.
// [RULE11] All 32 outputs update together and inputs sample together.
// [RULE12] A tag packet has the command bit and two flags, else zero.
// [RULE13] External events fire on the rising edge of the sync line.
// [RULE14] A driven start pulse idles low and stays high for 500 ns.
// [RULE15] After reset, unforced ports and both sync lines are inputs.
// [RULE16] The 1 s timer counts system clocks; each wrap is one event.
`include "dio_defs.svh"

module dio_sync_top #(
    parameter logic [3:0] FORCE_OUT       = 4'h0,  // Forced-output straps
    parameter logic       PULL_DOWN       = 1'b0,  // Pull-down build
    parameter int         SEC_CYCLES      = `SEC_CYCLES,
    parameter int         SEC_HIGH_CYCLES = `SEC_HIGH_CYCLES
)(
    input  wire logic        mclk,     // 40 MHz system clock
    input  wire logic        rst_b,    // Async reset, active low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB access phase
    input  wire logic        pwrite,   // APB write
    input  wire logic [7:0]  paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic      [31:0] prdata,   // APB read data
    output logic             pready,   // APB ready
    output logic             pslverr,  // APB error
    input  wire logic [31:0] ioIn,     // Line levels in
    output logic      [31:0] ioOut,    // Line levels out
    output logic      [31:0] ioOe,     // Line output enables
    input  wire logic        startIn,  // Start sync line in
    output logic             startOut, // Start sync line out
    output logic             startOe,  // Start sync line enable
    input  wire logic        secIn,    // Second sync line in
    output logic             secOut,   // Second sync line out
    output logic             secOe,    // Second sync line enable
    output logic             pktValid, // Tag packet valid
    input  wire logic        pktReady, // Tag packet taken
    output dio_pkg::tagpkt_s pkt,      // Tag packet word
    output logic             irq       // Interrupt, active high
);
    import dio_pkg::*;

    localparam int START_CYC = `START_PULSE_CYC;

    // ****************************************
    // APB slave
    // ****************************************
    logic [3:0]  dirReg;
    logic [31:0] outReg;
    logic [31:0] inReg;
    logic [4:0]  cfgReg;
    logic [13:0] perReg;
    logic [2:0]  statReg;
    logic [2:0]  maskReg;
    logic [31:0] prdataReg;
    logic        preadyReg;
    logic        pslverrReg;
    logic        tagBusy;
    logic [33:0] pinQ;
    logic [33:0] pinRise;

    // One-hot register select from the byte address
    function automatic logic [8:0] decode(input logic [7:0] a);
        if (a == `DIR_OFS) decode = 9'h001;
        else if (a == `OUT_OFS) decode = 9'h002;
        else if (a == `IN_OFS) decode = 9'h004;
        else if (a == `CFG_OFS) decode = 9'h008;
        else if (a == `CMD_OFS) decode = 9'h010;
        else if (a == `PER_OFS) decode = 9'h020;
        else if (a == `STAT_OFS) decode = 9'h040;
        else if (a == `MASK_OFS) decode = 9'h080;
        else if (a == `INFO_OFS) decode = 9'h100;
        else decode = 9'h000;
    endfunction

    wire logic [8:0] sel    = decode(paddr);
    wire logic       setup  = psel & ~penable;
    wire logic       done   = psel & penable & preadyReg;
    wire logic       wrDone = done & pwrite;
    wire logic       rdStat = done & ~pwrite & sel[6];
    wire logic       wrCmd  = wrDone & sel[4];

    // Read data is latched in setup, so the access phase needs no wait
    wire logic [31:0] rdMux =
        sel[0] ? {28'h0, dirReg} :
        sel[1] ? outReg :
        sel[2] ? inReg :
        sel[3] ? {27'h0, cfgReg} :
        sel[5] ? {18'h0, perReg} :
        sel[6] ? {29'h0, statReg} :
        sel[7] ? {29'h0, maskReg} :
        sel[8] ? {26'h0, tagBusy, PULL_DOWN, FORCE_OUT} : // see [RULE4]
        32'h0;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prdataReg  <= 32'h0;
            preadyReg  <= 1'b0;
            pslverrReg <= 1'b0;
        end else begin
            prdataReg  <= setup ? rdMux : prdataReg;
            preadyReg  <= setup;
            pslverrReg <= setup & (sel == 9'h000);
        end
    end

    assign prdata  = prdataReg;
    assign pready  = preadyReg;
    assign pslverr = pslverrReg;

    // ****************************************
    // Control registers
    // ****************************************
    wire logic [13:0] perWr = pwdata[13:0];
    wire logic [13:0] perClamp =
        (perWr < `PER_MIN_US) ? `PER_MIN_US :
        (perWr > `PER_MAX_US) ? `PER_MAX_US : perWr; // see [RULE5]

    // Forced ports stay outputs whatever software writes
    wire logic [3:0]  dirNext = (wrDone & sel[0]) ?
        (pwdata[3:0] | FORCE_OUT) : dirReg; // see [RULE2] [RULE3]
    wire logic [31:0] outNext = (wrDone & sel[1]) ? pwdata : outReg;
    wire logic [4:0]  cfgNext = (wrDone & sel[3]) ? pwdata[4:0] : cfgReg;
    wire logic [13:0] perNext = (wrDone & sel[5]) ? perClamp : perReg;
    wire logic [2:0]  maskNext = (wrDone & sel[7]) ? pwdata[2:0] : maskReg;

    // Unforced ports come up as inputs, forced ones as outputs at zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dirReg  <= FORCE_OUT; // see [RULE15] [RULE3]
            outReg  <= `OUT_RST;
            cfgReg  <= `CFG_RST; // see [RULE15]
            perReg  <= `PER_RST;
            maskReg <= `MASK_RST;
        end else begin
            dirReg  <= dirNext;
            outReg  <= outNext;
            cfgReg  <= cfgNext;
            perReg  <= perNext;
            maskReg <= maskNext;
        end
    end

    // ****************************************
    // Port lines
    // ****************************************
    logic [31:0] oeNext;
    logic [31:0] oeReg;

    // Each port direction bit spreads over its eight lines
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            assign oeNext[8*p +: 8] = {8{dirNext[p]}}; // see [RULE1]
        end
    endgenerate

    // One register stage drives all 32 lines on the same edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            oeReg <= {{8{FORCE_OUT[3]}}, {8{FORCE_OUT[2]}},
                      {8{FORCE_OUT[1]}}, {8{FORCE_OUT[0]}}};
        end else begin
            oeReg <= oeNext; // see [RULE11]
        end
    end

    assign ioOut = outReg; // see [RULE11]
    assign ioOe  = oeReg;

    sync_rise #(
        .W(34)
    ) u_pins (
        .clk   (mclk),
        .rst_b (rst_b),
        .d     ({secIn, startIn, ioIn}),
        .q     (pinQ),
        .rise  (pinRise)
    );

    // ****************************************
    // Stream sampling
    // ****************************************
    logic [5:0]  usCntReg;
    logic [13:0] perCntReg;
    wire logic   streamEn = cfgReg[`CFG_STREAM_BIT];
    wire logic   usTick = (usCntReg == 6'(`US_CYCLES - 1));
    wire logic   sampleEv = streamEn & usTick & (perCntReg == perReg - 14'h1);
    wire logic   cmdSample = wrCmd & pwdata[`CMD_SAMPLE_BIT];

    // Microsecond prescaler then period counter; jitter stays under 1 us
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            usCntReg  <= 6'h0;
            perCntReg <= 14'h0;
        end else begin
            usCntReg  <= (!streamEn || usTick) ? 6'h0 : usCntReg + 6'h1;
            perCntReg <= !streamEn ? 14'h0 :
                         sampleEv ? 14'h0 :
                         usTick ? perCntReg + 14'h1 : perCntReg; // see [RULE5]
        end
    end

    // All inputs captured in one edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            inReg <= 32'h0;
        end else if (sampleEv || cmdSample) begin
            inReg <= pinQ[31:0]; // see [RULE11] [RULE5]
        end
    end

    // ****************************************
    // Start events
    // ****************************************
    wire logic [1:0] startMode = cfgReg[`CFG_START_LSB +: 2];
    wire logic [1:0] secMode   = cfgReg[`CFG_SEC_LSB +: 2];
    wire logic startExt = (startMode == `MODE_EXT);
    wire logic softStart = wrCmd & pwdata[`CMD_START_BIT] & ~startExt;
    wire logic startEv = startExt ? pinRise[32] : softStart; // see [RULE8]
    logic [4:0] startCntReg;
    logic       startOutReg;
    logic       startOeReg;

    // Pulse is armed only when the mode drives the line
    wire logic [4:0] startCntNext =
        (softStart && startMode == `MODE_INTOUT) ? 5'(START_CYC) :
        (startCntReg != 5'h0) ? startCntReg - 5'h1 : 5'h0; // see [RULE14]

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            startCntReg <= 5'h0;
            startOutReg <= 1'b0;
            startOeReg  <= 1'b0;
        end else begin
            startCntReg <= startCntNext;
            startOutReg <= (startCntNext != 5'h0); // see [RULE14]
            startOeReg  <= (startMode == `MODE_INTOUT); // see [RULE9]
        end
    end

    assign startOut = startOutReg;
    assign startOe  = startOeReg;

    // ****************************************
    // Second events
    // ****************************************
    logic [31:0] secCntReg;
    logic [31:0] secHiReg;
    logic        secOutReg;
    logic        secOeReg;
    wire logic   secInt = (secMode != `MODE_EXT);
    wire logic   secWrap = secInt & (secCntReg == 32'(SEC_CYCLES - 1));
    wire logic   secEv = secInt ? secWrap : pinRise[33]; // see [RULE10]
    wire logic   secDrive = (secMode == `MODE_INTOUT);

    wire logic [31:0] secHiNext =
        (secWrap && secDrive) ? 32'(SEC_HIGH_CYCLES) :
        (secHiReg != 32'h0) ? secHiReg - 32'h1 : 32'h0;

    // Timer free-runs in the internal modes; a wrap is one event
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            secCntReg <= 32'h0;
            secHiReg  <= 32'h0;
            secOutReg <= 1'b0;
            secOeReg  <= 1'b0;
        end else begin
            secCntReg <= (!secInt || secWrap) ? 32'h0 :
                         secCntReg + 32'h1; // see [RULE16]
            secHiReg  <= secHiNext;
            secOutReg <= secDrive && (secHiNext != 32'h0); // see [RULE10]
            secOeReg  <= secDrive; // see [RULE15]
        end
    end

    assign secOut = secOutReg;
    assign secOe  = secOeReg;

    // ****************************************
    // Tag packets and interrupt
    // ****************************************
    tag_ev_s tagEv;
    assign tagEv.start = startEv; // see [RULE7]
    assign tagEv.sec   = secEv; // see [RULE7]

    tag_sender u_tag (
        .clk      (mclk),
        .rst_b    (rst_b),
        .ev       (tagEv),
        .pktReady (pktReady),
        .pktValid (pktValid),
        .pkt      (pkt),
        .busy     (tagBusy)
    );

    // Read clears only the bits that were shown; new events still set
    wire logic [2:0] statNext =
        (statReg & ~(rdStat ? prdataReg[2:0] : 3'h0)) |
        {sampleEv, secEv, startEv};
    logic irqReg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            statReg <= 3'h0;
            irqReg  <= 1'b0;
        end else begin
            statReg <= statNext;
            irqReg  <= |(statNext & maskNext);
        end
    end

    assign irq = irqReg;

    // ****************************************
    // Checks
    // ****************************************
    logic [4:0] startHi;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            startHi <= 5'h0;
        end else begin
            startHi <= startOut ? startHi + 5'h1 : 5'h0;
        end
    end

    sequence s_soft_int;
        wrCmd && pwdata[`CMD_START_BIT] && startMode == `MODE_INTOUT;
    endsequence

    a_start_width: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(startOut) |-> startHi == 5'(START_CYC)) // see [RULE14]
        else $error("start pulse width wrong");
    a_start_rise: assert property (@(posedge mclk) disable iff (!rst_b)
        s_soft_int |=> startOut && startOe) // see [RULE9]
        else $error("software start not driven out");
    a_ext_start: assert property (@(posedge mclk) disable iff (!rst_b)
        startExt && pinRise[32] |-> tagEv.start && !startOe) // see [RULE13]
        else $error("external start edge not taken");
    a_forced_out: assert property (@(posedge mclk) disable iff (!rst_b)
        (dirReg & FORCE_OUT) == FORCE_OUT) // see [RULE3]
        else $error("forced port left output mode");
    a_out_together: assert property (@(posedge mclk) disable iff (!rst_b)
        !$stable(ioOut) |-> $past(wrDone && sel[1])) // see [RULE11]
        else $error("outputs changed without a write");
    a_sec_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
        secInt && secCntReg == 32'(SEC_CYCLES - 1) |-> tagEv.sec
            ##1 secCntReg == 32'h0) // see [RULE16]
        else $error("second timer wrap gave no event");
    a_stat_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
        startEv |=> statReg[0]) // see [RULE6]
        else $error("start event not recorded");
    a_sample_take: assert property (@(posedge mclk) disable iff (!rst_b)
        sampleEv |=> inReg == $past(pinQ[31:0])) // see [RULE5]
        else $error("stream sample not captured");
endmodule

// ==== testbench/ctrl_model.sv ====
// ****
// Crate controller taking tag packets
// ****
module ctrl_model
    import dio_pkg::*;
(
    input  wire logic mclk,     // System clock
    input  wire logic rst_b,    // Async reset, active low
    input  wire logic pktValid, // Packet on offer
    input  dio_pkg::tagpkt_s pkt, // Packet word
    input  wire logic slow,     // Stall three cycles per packet
    output logic      pktReady, // Packet taken
    output tagpkt_s   lastPkt,  // Last packet taken
    output int        pktCount  // Packets taken
);
    timeunit 1ns;
    timeprecision 1ps;
    int waitCnt;

    // Ready is held until the taking edge, then dropped for a cycle
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pktReady <= 1'b0;
            waitCnt  <= 0;
            pktCount <= 0;
            lastPkt  <= '0;
        end else if (pktValid && pktReady) begin
            pktReady <= 1'b0;
            lastPkt  <= pkt;
            pktCount <= pktCount + 1;
        end else if (pktValid) begin
            if (waitCnt >= (slow ? 3 : 0)) begin
                pktReady <= 1'b1;
                waitCnt  <= 0;
            end else begin
                waitCnt <= waitCnt + 1;
            end
        end
    end
endmodule

// ==== testbench/digital_io_ports_with_sync_tags_test.sv ====
`include "dio_defs.svh"

module digital_io_ports_with_sync_tags_test;
    import dio_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, ioOut, ioOe, rd;
    logic pready, pslverr, startOut, startOe, secOut, secOe, er;
    logic pktValid, pktReady, irq, slow = 0, startExt = 0, secExt = 0;
    tagpkt_s pkt, lastPkt;
    int pktCount, err_count = 0, tests_run = 0, startHi = 0, secHi = 0;

    // ****
    // Pins: driven value, else pull-up level
    // ****
    wire logic [31:0] ioIn = (ioOe & ioOut) | ~ioOe;
    wire logic startIn = startOe ? startOut : startExt;
    wire logic secIn = secOe ? secOut : secExt;

    always #12.5 mclk = ~mclk;

    dio_sync_top #(.FORCE_OUT(4'h2), .PULL_DOWN(1'b0),
        .SEC_CYCLES(100), .SEC_HIGH_CYCLES(40)) u_dio_sync_top (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .startIn(startIn),
        .startOut(startOut), .startOe(startOe), .secIn(secIn),
        .secOut(secOut), .secOe(secOe), .pktValid(pktValid),
        .pktReady(pktReady), .pkt(pkt), .irq(irq));

    ctrl_model u_ctrl_model (.mclk(mclk), .rst_b(rst_b),
        .pktValid(pktValid), .pkt(pkt), .slow(slow),
        .pktReady(pktReady), .lastPkt(lastPkt), .pktCount(pktCount));

    // Pulse widths measured in cycles
    always @(posedge mclk) begin
        if (startOut === 1'b1) startHi++;
        if (secOut === 1'b1) secHi++;
    end

    task automatic test_done;
        if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; waits for pready, then an idle cycle
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // Rising edge on the start line, or on the second line when sec is set
    task automatic pulse(input logic sec);
        @(posedge mclk);
        if (sec) secExt <= 1'b1;
        else startExt <= 1'b1;
        repeat (5) @(posedge mclk);
        secExt <= 1'b0;
        startExt <= 1'b0;
        repeat (20) @(posedge mclk);
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        chk("oe", ioOe, 32'h0000_ff00);
        chk("out", ioOut, 32'h0);
        chk("syncoe", {startOe, secOe}, 32'h0);
        apb(0, `DIR_OFS, 0);
        chk("dir", rd, 32'h2);
        apb(0, `INFO_OFS, 0);
        chk("info", rd & 32'h1f, 32'h2);
        apb(1, `CMD_OFS, 32'h2);
        apb(0, `IN_OFS, 0);
        chk("in", rd, 32'hffff_00ff);
        apb(1, `DIR_OFS, 32'h5);
        apb(1, `OUT_OFS, 32'ha5a5_a5a5);
        chk("oe2", ioOe, 32'h00ff_ffff);
        chk("out2", ioOut, 32'ha5a5_a5a5);
        apb(0, `DIR_OFS, 0);
        chk("dir2", rd, 32'h7);
        repeat (4) @(posedge mclk);
        apb(1, `CMD_OFS, 32'h2);
        apb(0, `IN_OFS, 0);
        chk("in2", rd, 32'hffa5_a5a5);
        apb(0, 8'h40, 0);
        chk("slverr", er, 32'h1);
        chk("slvrd", rd, 32'h0);
        apb(1, `MASK_OFS, 32'h7);
        apb(1, `CFG_OFS, 32'h2);
        // Line enables follow the mode one edge after the write
        @(posedge mclk);
        chk("startoe", startOe, 32'h1);
        apb(1, `CMD_OFS, 32'h1);
        repeat (30) @(posedge mclk);
        chk("starthi", startHi, 20);
        chk("cnt1", pktCount, 1);
        chk("pkt1", lastPkt, 32'h100_1000);
        chk("irq", irq, 32'h1);
        apb(0, `STAT_OFS, 0);
        chk("stat", rd, 32'h1);
        chk("irq0", irq, 32'h0);
        slow <= 1'b1;
        apb(1, `CFG_OFS, 32'h0);
        pulse(1'b0);
        chk("cnt2", pktCount, 2);
        apb(1, `CMD_OFS, 32'h1);
        repeat (10) @(posedge mclk);
        chk("cnt3", pktCount, 2);
        apb(1, `CFG_OFS, 32'h8);
        @(posedge mclk);
        chk("secoe", {startOe, secOe}, 32'h1);
        repeat (150) @(posedge mclk);
        chk("cnt4", pktCount, 3);
        chk("pkt4", lastPkt, 32'h100_2000);
        chk("sechi", secHi, 40);
        apb(1, `CFG_OFS, 32'h0);
        pulse(1'b1);
        chk("cnt5", pktCount, 4);
        chk("pkt5", lastPkt, 32'h100_2000);
        // Internal start and second modes that leave the lines undriven
        apb(1, `CFG_OFS, 32'hd);
        @(posedge mclk);
        chk("intoe", {startOe, secOe}, 32'h0);
        apb(1, `CMD_OFS, 32'h1);
        repeat (20) @(posedge mclk);
        chk("cnt6", pktCount, 5);
        chk("pkt6", lastPkt, 32'h100_1000);
        chk("starthi2", startHi, 20);
        repeat (100) @(posedge mclk);
        chk("cnt7", pktCount, 6);
        chk("pkt7", lastPkt, 32'h100_2000);
        chk("sechi2", secHi, 40);
        apb(1, `PER_OFS, 32'h5);
        apb(0, `PER_OFS, 0);
        chk("per", rd, 32'ha);
        apb(1, `CFG_OFS, 32'h10);
        repeat (1000) @(posedge mclk);
        apb(0, `STAT_OFS, 0);
        chk("stream", rd & 32'h4, 32'h4);
        test_done();
    end

    // Whole run needs about 1450 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        test_done();
    end
endmodule
